// *** logic/vtl_top.sv ***
// Virtual terminal logic: virtual inputs, analog-as-digital inputs and
// delayed virtual outputs, configured over an APB slave.
// Assumes physical inputs and analog words arrive from other domains and
// output function results and init done come from logic on this clock.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
module vtl_top
  import vtl_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NUM_VIN-1:0] PHYS_INPUT,
  input wire logic [ANALOG_W-1:0] ANALOG_CHANNEL_ONE,
  input wire logic [ANALOG_W-1:0] ANALOG_CHANNEL_TWO,
  input wire logic [ANALOG_W-1:0] ANALOG_CHANNEL_THREE,
  input wire logic [NUM_OUT_FUNC-1:0] OUTPUT_FUNC_RESULT,
  input wire logic INIT_DONE,
  output logic [NUM_FUNC-1:0] FUNC_ACTIVE,
  output logic FORWARD_RUN_COMMAND,
  output logic DRIVE_STOP,
  output logic [7:0] FAULT_CODE,
  output logic [NUM_VOUT-1:0] VIRTUAL_OUTPUT,
  output logic IRQ
);

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base);
    hit = (addr == base);
  endfunction

  // Word slot of addr within an array of n registers at base, or -1
  function automatic int slot(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base,
                              input int n);
    int idx;
    idx = -1;
    for (int k = 0; k < n; k++) begin
      if (addr == ADDR_W'(base + ADDR_W'(4 * k))) begin
        idx = k;
      end
    end
    slot = idx;
  endfunction

  logic rst_s1;
  logic rst_n;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Analog words pass the same two stages; a converter that updates
  // its word in one step keeps the sampled word coherent.
  logic [NUM_VIN-1:0] phys_s1;
  logic [NUM_VIN-1:0] phys_in;
  logic [ANALOG_W-1:0] ain_s1 [NUM_AIN];
  logic [ANALOG_W-1:0] ain_word [NUM_AIN];

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      phys_s1 <= '0;
      phys_in <= '0;
      for (int k = 0; k < NUM_AIN; k++) begin
        ain_s1[k] <= '0;
        ain_word[k] <= '0;
      end
    end else begin
      phys_s1 <= PHYS_INPUT;
      phys_in <= phys_s1;
      ain_s1[0] <= ANALOG_CHANNEL_ONE;
      ain_s1[1] <= ANALOG_CHANNEL_TWO;
      ain_s1[2] <= ANALOG_CHANNEL_THREE;
      for (int k = 0; k < NUM_AIN; k++) begin
        ain_word[k] <= ain_s1[k];
      end
    end
  end

  logic [FUNC_W-1:0] vin_func [NUM_VIN];
  logic [FUNC_W-1:0] ain_func [NUM_AIN];
  logic [FUNC_W-1:0] vout_func [NUM_VOUT];
  logic [DELAY_W-1:0] vout_delay [NUM_VOUT];
  logic [NUM_VIN-1:0] virtual_input_source_mode;
  logic [NUM_VIN-1:0] virtual_input_state_bits;
  logic [NUM_AIN-1:0] analog_as_digital_polarity;
  logic [NUM_VOUT-1:0] virtual_output_state_setting;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;
  logic fault_clear;
  logic wr_en;
  int wr_vin;
  int wr_ain;
  int wr_vfn;
  int wr_vdl;

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign wr_vin = slot(PADDR, ADDR_VIN_FUNC, NUM_VIN);
  assign wr_ain = slot(PADDR, ADDR_AIN_FUNC, NUM_AIN);
  assign wr_vfn = slot(PADDR, ADDR_VOUT_FUNC, NUM_VOUT);
  assign wr_vdl = slot(PADDR, ADDR_VOUT_DELAY, NUM_VOUT);
  assign irq_clear = (wr_en && hit(PADDR, ADDR_IRQ_CLEAR)) ? PWDATA[IRQ_W-1:0] : '0;
  assign fault_clear = wr_en && hit(PADDR, ADDR_FAULT_CLEAR) && PWDATA[0];

  // Out-of-range codes and delays are dropped and the old value kept
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_VIN; k++) begin
        vin_func[k] <= FUNC_RST;
      end
      for (int k = 0; k < NUM_AIN; k++) begin
        ain_func[k] <= FUNC_RST;
      end
      for (int k = 0; k < NUM_VOUT; k++) begin
        vout_func[k] <= FUNC_RST;
        vout_delay[k] <= VOUT_DELAY_RST;
      end
      virtual_input_source_mode <= DIGITS5_RST;
      virtual_input_state_bits <= DIGITS5_RST;
      analog_as_digital_polarity <= DIGITS3_RST;
      virtual_output_state_setting <= DIGITS5_RST;
      irq_enable <= '0;
    end else if (wr_en) begin
      if (wr_vin >= 0 && PWDATA[31:FUNC_W] == '0 && PWDATA[FUNC_W-1:0] <= VIN_FUNC_MAX) begin
        vin_func[wr_vin] <= PWDATA[FUNC_W-1:0];
      end
      if (wr_ain >= 0 && PWDATA[31:FUNC_W] == '0 && PWDATA[FUNC_W-1:0] <= VIN_FUNC_MAX) begin
        ain_func[wr_ain] <= PWDATA[FUNC_W-1:0];
      end
      if (wr_vfn >= 0 && PWDATA[31:FUNC_W] == '0 && PWDATA[FUNC_W-1:0] <= VOUT_FUNC_MAX) begin
        vout_func[wr_vfn] <= PWDATA[FUNC_W-1:0];
      end
      if (wr_vdl >= 0 && PWDATA[31:DELAY_W] == '0 && PWDATA[DELAY_W-1:0] <= VOUT_DELAY_MAX) begin
        vout_delay[wr_vdl] <= PWDATA[DELAY_W-1:0];
      end
      if (hit(PADDR, ADDR_SRC_MODE)) begin
        virtual_input_source_mode <= PWDATA[NUM_VIN-1:0];
      end
      if (hit(PADDR, ADDR_STATE_BITS)) begin
        virtual_input_state_bits <= PWDATA[NUM_VIN-1:0];
      end
      if (hit(PADDR, ADDR_POLARITY)) begin
        analog_as_digital_polarity <= PWDATA[NUM_AIN-1:0];
      end
      if (hit(PADDR, ADDR_VOUT_SETTING)) begin
        virtual_output_state_setting <= PWDATA[NUM_VOUT-1:0];
      end
      if (hit(PADDR, ADDR_IRQ_ENABLE)) begin
        irq_enable <= PWDATA[IRQ_W-1:0];
      end
    end
  end

  // Analog channels as digital inputs, with hysteresis band
  logic [NUM_AIN-1:0] ain_level;
  logic [NUM_AIN-1:0] ain_active;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ain_level <= '0;
    end else begin
      for (int k = 0; k < NUM_AIN; k++) begin
        if (ain_word[k] >= AIN_HIGH_CODE) begin
          ain_level[k] <= 1'b1;
        end else if (ain_word[k] <= AIN_LOW_CODE) begin
          ain_level[k] <= 1'b0;
        end
      end
    end
  end

  assign ain_active = ain_level ^ analog_as_digital_polarity;

  // 0.1 s tick shared by all output delays
  logic [TICK_W-1:0] tick_count;
  logic tick;

  assign tick = (tick_count == TICK_W'(TICK_COUNT - 1));

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= '0;
    end else if (tick) begin
      tick_count <= '0;
    end else begin
      tick_count <= TICK_W'(tick_count + 1'b1);
    end
  end

  logic [NUM_VOUT-1:0] vout_raw;
  logic [NUM_VOUT-1:0] vout_delayed;
  logic [NUM_VOUT-1:0] virtual_output;
  logic [NUM_VIN-1:0] virtual_input;

  always_comb begin
    for (int k = 0; k < NUM_VOUT; k++) begin
      if (vout_func[k] == FN_NONE) begin
        vout_raw[k] = phys_in[k];
      end else begin
        vout_raw[k] = OUTPUT_FUNC_RESULT[vout_func[k]];
      end
    end
  end

  logic clk_sys_w;
  assign clk_sys_w = CLK_SYS;

  for (genvar g = 0; g < NUM_VOUT; g++) begin : g_delay
    vtl_delay #(
      .WIDTH(DELAY_W)
    ) u_delay (
      .clk(clk_sys_w),
      .rst_n(rst_n),
      .tick(tick),
      .din(vout_raw[g]),
      .delay(vout_delay[g]),
      .dout(vout_delayed[g])
    );
  end

  // A set digit inverts the sense of its output
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      virtual_output <= '0;
    end else begin
      virtual_output <= vout_delayed ^ virtual_output_state_setting;
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_VIN; k++) begin
      if (virtual_input_source_mode[k]) begin
        virtual_input[k] = virtual_input_state_bits[k];
      end else begin
        virtual_input[k] = virtual_output[k];
      end
    end
  end

  // Code 0 carries no function, so bit 0 never sets
  logic [NUM_FUNC-1:0] next_func_active;
  logic [NUM_FUNC-1:0] func_active;

  always_comb begin
    next_func_active = '0;
    for (int k = 0; k < NUM_VIN; k++) begin
      if (virtual_input[k] && vin_func[k] != FN_NONE) begin
        next_func_active[vin_func[k]] = 1'b1;
      end
    end
    for (int k = 0; k < NUM_AIN; k++) begin
      if (ain_active[k] && ain_func[k] != FN_NONE) begin
        next_func_active[ain_func[k]] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      func_active <= '0;
    end else begin
      func_active <= next_func_active;
    end
  end

  logic fwd_cmd;
  logic fault_prev;
  logic fault_latched;
  logic fault_rise;
  logic next_fwd_cmd;

  assign next_fwd_cmd = func_active[FN_FORWARD_RUN] && INIT_DONE;
  assign fault_rise = func_active[FN_USER_FAULT_ONE] && !fault_prev;

  // A new fault edge in the same cycle as a clear keeps the fault
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      fwd_cmd <= 1'b0;
      fault_prev <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      fwd_cmd <= next_fwd_cmd && !fault_latched && !fault_rise;
      fault_prev <= func_active[FN_USER_FAULT_ONE];
      fault_latched <= fault_rise || (fault_latched && !fault_clear);
    end
  end

  assign irq_event[IRQ_FAULT] = fault_rise;
  assign irq_event[IRQ_FWD_RUN] = next_fwd_cmd && !fault_latched && !fault_rise && !fwd_cmd;
  assign irq_event[IRQ_VOUT_CHANGE] = (virtual_output != (vout_delayed ^
                                       virtual_output_state_setting));

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  // Read data is fetched in the setup cycle so the access answers at once
  logic [31:0] next_prdata;
  logic next_err;
  int rd_vin;
  int rd_ain;
  int rd_vfn;
  int rd_vdl;

  assign rd_vin = slot(PADDR, ADDR_VIN_FUNC, NUM_VIN);
  assign rd_ain = slot(PADDR, ADDR_AIN_FUNC, NUM_AIN);
  assign rd_vfn = slot(PADDR, ADDR_VOUT_FUNC, NUM_VOUT);
  assign rd_vdl = slot(PADDR, ADDR_VOUT_DELAY, NUM_VOUT);

  always_comb begin
    next_prdata = '0;
    next_err = 1'b0;
    if (rd_vin >= 0) begin
      next_prdata[FUNC_W-1:0] = vin_func[rd_vin];
    end else if (rd_ain >= 0) begin
      next_prdata[FUNC_W-1:0] = ain_func[rd_ain];
    end else if (rd_vfn >= 0) begin
      next_prdata[FUNC_W-1:0] = vout_func[rd_vfn];
    end else if (rd_vdl >= 0) begin
      next_prdata[DELAY_W-1:0] = vout_delay[rd_vdl];
    end else if (hit(PADDR, ADDR_SRC_MODE)) begin
      next_prdata[NUM_VIN-1:0] = virtual_input_source_mode;
    end else if (hit(PADDR, ADDR_STATE_BITS)) begin
      next_prdata[NUM_VIN-1:0] = virtual_input_state_bits;
    end else if (hit(PADDR, ADDR_POLARITY)) begin
      next_prdata[NUM_AIN-1:0] = analog_as_digital_polarity;
    end else if (hit(PADDR, ADDR_VOUT_SETTING)) begin
      next_prdata[NUM_VOUT-1:0] = virtual_output_state_setting;
    end else if (hit(PADDR, ADDR_STATUS)) begin
      next_prdata[4:0] = virtual_input;
      next_prdata[10:8] = ain_active;
      next_prdata[20:16] = virtual_output;
      next_prdata[24] = fwd_cmd;
      next_prdata[25] = fault_latched;
    end else if (hit(PADDR, ADDR_IRQ_STATUS)) begin
      next_prdata[IRQ_W-1:0] = irq_status;
    end else if (hit(PADDR, ADDR_IRQ_ENABLE)) begin
      next_prdata[IRQ_W-1:0] = irq_enable;
    end else if (!hit(PADDR, ADDR_IRQ_CLEAR) && !hit(PADDR, ADDR_FAULT_CLEAR)) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= PWRITE ? '0 : next_prdata;
      PSLVERR <= next_err;
    end
  end

  assign PREADY = 1'b1;
  assign FUNC_ACTIVE = func_active;
  assign FORWARD_RUN_COMMAND = fwd_cmd;
  assign DRIVE_STOP = fault_latched;
  assign FAULT_CODE = fault_latched ? USER_FAULT_ONE_CODE : NO_FAULT_CODE;
  assign VIRTUAL_OUTPUT = virtual_output;
  assign IRQ = |(irq_status & irq_enable);

endmodule

// *** shared/vtl_pkg.sv ***
// Constants, register map and timing for the virtual terminal logic block.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package vtl_pkg;

  localparam int NUM_VIN = 5;
  localparam int NUM_AIN = 3;
  localparam int NUM_VOUT = 5;
  localparam int FUNC_W = 6;
  localparam int NUM_FUNC = 60;
  localparam int NUM_OUT_FUNC = 41;
  localparam int DELAY_W = 16;
  localparam int ANALOG_W = 12;
  localparam int ADDR_W = 12;

  localparam logic [FUNC_W-1:0] VIN_FUNC_MAX = 6'h3b;
  localparam logic [FUNC_W-1:0] VOUT_FUNC_MAX = 6'h28;
  localparam logic [FUNC_W-1:0] FN_NONE = 6'h00;
  localparam logic [FUNC_W-1:0] FN_FORWARD_RUN = 6'h01;
  localparam logic [FUNC_W-1:0] FN_USER_FAULT_ONE = 6'h2c;
  localparam logic [7:0] USER_FAULT_ONE_CODE = 8'h1b;
  localparam logic [7:0] NO_FAULT_CODE = 8'h00;

  // Delay settings are held in tenths of a second
  localparam logic [DELAY_W-1:0] VOUT_DELAY_MAX = 16'h8ca0;
  localparam logic [DELAY_W-1:0] VOUT_DELAY_RST = 16'h0000;
  localparam logic [FUNC_W-1:0] FUNC_RST = 6'h00;
  localparam logic [4:0] DIGITS5_RST = 5'h00;
  localparam logic [2:0] DIGITS3_RST = 3'h0;

  // Analog words are in 10 mV steps
  localparam int ANALOG_LSB_MV = 10;
  localparam int AIN_HIGH_V = 7;
  localparam int AIN_LOW_V = 3;
  localparam logic [ANALOG_W-1:0] AIN_HIGH_CODE = ANALOG_W'(AIN_HIGH_V * 1000 / ANALOG_LSB_MV);
  localparam logic [ANALOG_W-1:0] AIN_LOW_CODE = ANALOG_W'(AIN_LOW_V * 1000 / ANALOG_LSB_MV);

  localparam int CLK_MHZ = 100;
  localparam int DELAY_TICK_MS = 100;
  localparam int TICK_CYCLES = DELAY_TICK_MS * CLK_MHZ * 1000;
  localparam int TICK_W = 24;

  localparam logic [ADDR_W-1:0] ADDR_VIN_FUNC = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_SRC_MODE = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_STATE_BITS = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_AIN_FUNC = 12'h01c;
  localparam logic [ADDR_W-1:0] ADDR_POLARITY = 12'h028;
  localparam logic [ADDR_W-1:0] ADDR_VOUT_FUNC = 12'h02c;
  localparam logic [ADDR_W-1:0] ADDR_VOUT_DELAY = 12'h040;
  localparam logic [ADDR_W-1:0] ADDR_VOUT_SETTING = 12'h054;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h058;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h05c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 12'h060;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 12'h064;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_CLEAR = 12'h068;

  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_FWD_RUN = 1;
  localparam int IRQ_VOUT_CHANGE = 2;

endpackage

// *** logic/vtl_delay.sv ***
// One virtual output delay stage counting 0.1 s ticks.
// Assumes tick is a one-cycle pulse from the same clock domain.
module vtl_delay
  import vtl_pkg::*;
#(
  parameter int WIDTH = DELAY_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic din,
  input wire logic [WIDTH-1:0] delay,
  output logic dout
);

  logic held;
  logic pending;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  assign next_count = WIDTH'(count + 1'b1);

  // The first tick may come at any time after a change, so the wait is
  // between delay-1 and delay ticks; good enough at 0.1 s resolution.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 1'b0;
      pending <= 1'b0;
      count <= '0;
      dout <= 1'b0;
    end else if (din != held) begin
      held <= din;
      count <= '0;
      if (delay == '0) begin
        dout <= din;
        pending <= 1'b0;
      end else begin
        pending <= 1'b1;
      end
    end else if (pending && tick) begin
      count <= next_count;
      if (next_count >= delay) begin
        dout <= held;
        pending <= 1'b0;
      end
    end
  end

endmodule

// *** logic/vtl_top_unused_guard.sv ***
// (intentionally empty)

// *** tb/vtl_monitor.sv ***
// Checker on the virtual terminal logic top pins.
// Assumes one clock domain; bound to every vtl_top instance below.
module vtl_monitor
  import vtl_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic INIT_DONE,
  input wire logic [NUM_FUNC-1:0] FUNC_ACTIVE,
  input wire logic FORWARD_RUN_COMMAND,
  input wire logic DRIVE_STOP,
  input wire logic [7:0] FAULT_CODE,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  logic wr_acc;
  logic clr_acc;
  logic irq_off;
  logic fwd_cause;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign clr_acc = wr_acc && PADDR == ADDR_FAULT_CLEAR && PWDATA[0];
  assign irq_off = wr_acc && PADDR == ADDR_IRQ_ENABLE && PWDATA[2:0] == 3'h0;
  assign fwd_cause = FUNC_ACTIVE[FN_FORWARD_RUN] && INIT_DONE && !DRIVE_STOP;
  property p_func_none; FUNC_ACTIVE[0] == 1'b0; endproperty
  a_func_none: assert property (p_func_none) else $error("code zero active");
  property p_fault_code; FAULT_CODE == (DRIVE_STOP ? USER_FAULT_ONE_CODE : NO_FAULT_CODE);
  endproperty
  a_fault_code: assert property (p_fault_code) else $error("fault code wrong");
  property p_fault_set; $rose(FUNC_ACTIVE[FN_USER_FAULT_ONE]) |=> DRIVE_STOP; endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");
  property p_fault_cause; $rose(DRIVE_STOP) |-> $past(FUNC_ACTIVE[FN_USER_FAULT_ONE]);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("stop without fault");
  property p_fault_hold; $fell(DRIVE_STOP) |-> $past(clr_acc); endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped alone");
  property p_fwd_gate;
    FORWARD_RUN_COMMAND |-> $past(INIT_DONE) && $past(FUNC_ACTIVE[FN_FORWARD_RUN]);
  endproperty
  a_fwd_gate: assert property (p_fwd_gate) else $error("run without cause");
  // A fault edge in the same cycle suppresses the run request
  property p_fwd_on;
    fwd_cause && !$rose(FUNC_ACTIVE[FN_USER_FAULT_ONE]) |=> FORWARD_RUN_COMMAND;
  endproperty
  a_fwd_on: assert property (p_fwd_on) else $error("run not raised");
  property p_stop_run; DRIVE_STOP ##1 DRIVE_STOP |-> !FORWARD_RUN_COMMAND; endproperty
  a_stop_run: assert property (p_stop_run) else $error("run during fault");
  property p_irq_mask; irq_off |=> !IRQ; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
  c_fault: cover property ($rose(DRIVE_STOP));
  c_fwd: cover property ($rose(FORWARD_RUN_COMMAND));
  c_clear: cover property (clr_acc ##1 !DRIVE_STOP);
endmodule

bind vtl_top vtl_monitor mon_u (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .INIT_DONE(INIT_DONE),
  .FUNC_ACTIVE(FUNC_ACTIVE), .FORWARD_RUN_COMMAND(FORWARD_RUN_COMMAND),
  .DRIVE_STOP(DRIVE_STOP), .FAULT_CODE(FAULT_CODE), .IRQ(IRQ));

// *** tb/vtl_board_model.sv ***
// Control board terminals and analog sources feeding the block.
// Assumes the bench calls its tasks just after a rising clock edge.
module vtl_board_model
  import vtl_pkg::*;
(
  input wire logic clk,
  output logic [NUM_VIN-1:0] phys,
  output logic [ANALOG_W-1:0] ain [NUM_AIN]
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    phys = '0;
    ain = '{default: '0};
  end
  task automatic set_phys(input logic [NUM_VIN-1:0] v);
    @(posedge clk);
    phys <= v;
  endtask
  // Task waits three cycles: two for the synchronisers and one for the level stage
  task automatic set_ain(input int ch, input logic [ANALOG_W-1:0] v);
    @(posedge clk);
    ain[ch] <= v;
    repeat (3) @(posedge clk);
  endtask
endmodule

// *** tb/virtual_terminal_logic_test.sv ***
// Self-checking bench for the virtual terminal logic block.
// Assumes the checker is bound to vtl_top; ticks shortened to 10 cycles.
module virtual_terminal_logic_test
  import vtl_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 10;
  localparam logic [ADDR_W-1:0] LIM_A [4] = '{ADDR_VIN_FUNC, ADDR_AIN_FUNC,
    ADDR_VOUT_FUNC, ADDR_VOUT_DELAY};
  localparam logic [31:0] LIM_BAD [4] = '{32'h3c, 32'h3c, 32'h29, 32'h8ca1};
  localparam logic [31:0] LIM_OK [4] = '{32'h3b, 32'h3b, 32'h28, 32'h8ca0};
  localparam logic [ANALOG_W-1:0] AIN_V [8] = '{12'h28a, 12'h2bc, 12'h1f4, 12'h12d,
    12'h12c, 12'h1f4, 12'h1f4, 12'h2bc};
  localparam logic [7:0] AIN_POL = 8'hc0;
  localparam logic [7:0] AIN_EXP = 8'h4e;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [NUM_OUT_FUNC-1:0] ofr = '0;
  logic init_done = 1'b0;
  logic [NUM_VIN-1:0] phys;
  logic [ANALOG_W-1:0] ain [NUM_AIN];
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic forward_run_command;
  logic stop;
  logic irq;
  logic [NUM_FUNC-1:0] fa;
  logic [7:0] fcode;
  logic [NUM_VOUT-1:0] vout;
  logic [32:0] rd_q [$];
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  vtl_top #(.TICK_COUNT(TICKS)) dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PHYS_INPUT(phys), .ANALOG_CHANNEL_ONE(ain[0]),
    .ANALOG_CHANNEL_TWO(ain[1]), .ANALOG_CHANNEL_THREE(ain[2]), .OUTPUT_FUNC_RESULT(ofr),
    .INIT_DONE(init_done), .FUNC_ACTIVE(fa), .FORWARD_RUN_COMMAND(forward_run_command), .DRIVE_STOP(stop),
    .FAULT_CODE(fcode), .VIRTUAL_OUTPUT(vout), .IRQ(irq));
  vtl_board_model board_u (.clk(clk_sys), .phys(phys), .ain(ain));
  task automatic stop_test;
    if (rd_q.size() != 0)
      n_fail++;
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_read(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_port(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t port %h exp %h", $time, got, exp);
    end
  endtask
  // Leading edge keeps one idle cycle so no strobe is driven twice at one step
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic err);
    rd_q.push_back({err, d});
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() > 0)
      check_read({pslverr, prdata}, rd_q.pop_front());
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    logic [NUM_VIN-1:0] v;
    void'($urandom(8));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 22; i++) rd(ADDR_W'(i * 4), 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(LIM_A[i], LIM_BAD[i]);
      rd(LIM_A[i], 32'h0, 1'b0);
      wr(LIM_A[i], LIM_OK[i]);
      rd(LIM_A[i], LIM_OK[i], 1'b0);
      wr(LIM_A[i], 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      v = NUM_VIN'($urandom()) | 5'h01;
      board_u.set_phys(v);
      repeat (8) @(posedge clk_sys);
      check_port(32'(vout), 32'(v));
    end
    wr(ADDR_VOUT_SETTING, 32'h1);
    repeat (6) @(posedge clk_sys);
    check_port(32'(vout), 32'(v ^ 5'h01));
    wr(ADDR_VOUT_SETTING, 32'h0);
    board_u.set_phys(5'h00);
    wr(ADDR_VOUT_FUNC + 12'h8, 32'h5);
    wr(ADDR_VOUT_DELAY + 12'h8, 32'h3);
    ofr[5] <= 1'b1;
    repeat (15) @(posedge clk_sys);
    check_port(32'(vout[2]), 32'h0);
    repeat (25) @(posedge clk_sys);
    check_port(32'(vout[2]), 32'h1);
    ofr[5] <= 1'b0;
    repeat (12) @(posedge clk_sys);
    ofr[5] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ofr[5] <= 1'b0;
    repeat (17) @(posedge clk_sys);
    check_port(32'(vout[2]), 32'h1);
    repeat (18) @(posedge clk_sys);
    check_port(32'(vout[2]), 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h4, 1'b0);
    check_port(32'(irq), 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h4);
    @(negedge clk_sys);
    check_port(32'(irq), 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h4);
    @(negedge clk_sys);
    check_port(32'(irq), 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h3);
    wr(ADDR_VIN_FUNC, 32'h1);
    wr(ADDR_SRC_MODE, 32'h1);
    wr(ADDR_STATE_BITS, 32'h1);
    repeat (4) @(posedge clk_sys);
    check_port(32'(fa[FN_FORWARD_RUN]), 32'h1);
    check_port(32'(forward_run_command), 32'h0);
    init_done <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check_port(32'(forward_run_command), 32'h1);
    check_port(32'(irq), 32'h1);
    wr(ADDR_STATE_BITS, 32'h0);
    repeat (4) @(posedge clk_sys);
    check_port(32'(fa[FN_FORWARD_RUN]), 32'h0);
    wr(ADDR_STATE_BITS, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h7);
    wr(ADDR_VIN_FUNC + 12'h4, 32'h2c);
    board_u.set_phys(5'h02);
    repeat (10) @(posedge clk_sys);
    check_port(32'(stop), 32'h1);
    check_port(32'(fcode), 32'h1b);
    check_port(32'(forward_run_command), 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h5, 1'b0);
    rd(ADDR_STATUS, 32'h02020003, 1'b0);
    board_u.set_phys(5'h00);
    repeat (8) @(posedge clk_sys);
    wr(ADDR_FAULT_CLEAR, 32'h1);
    repeat (4) @(posedge clk_sys);
    check_port({23'h0, stop, fcode}, 32'h0);
    check_port(32'(forward_run_command), 32'h1);
    check_port(32'(irq), 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    @(negedge clk_sys);
    check_port(32'(irq), 32'h0);
    wr(ADDR_AIN_FUNC, 32'ha);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_POLARITY, 32'(AIN_POL[i]));
      board_u.set_ain(0, AIN_V[i]);
      repeat (4) @(posedge clk_sys);
      check_port(32'(fa[10]), 32'(AIN_EXP[i]));
    end
    stop_test();
  end
endmodule
